// File: rtl/clock_unit_defines.vh
// Constants for the reset and clock unit register block.
// Assumes inclusion by bare name from the design files in rtl/.
`ifndef CLOCK_UNIT_DEFINES_VH
`define CLOCK_UNIT_DEFINES_VH

// ==========================================================
// Register offsets.
`define OFS_PLL_CONFIGURATION     8'h00
`define OFS_DIVIDER_CONFIGURATION 8'h04
`define OFS_CLOCK_FLAG_STATUS     8'h08
`define OFS_CLOCK_CONTROL         8'h0c
`define OFS_INTERRUPT_MASK        8'h10
`define OFS_WRITE_PROTECT         8'h14

// ==========================================================
// Reset values.
`define RST_PLL_CONFIGURATION     16'h03c7
`define RST_DIVIDER_CONFIGURATION 16'h0000
`define RST_FLAG_HARD             16'h0020
`define RST_FLAG_SOFT             16'h0021
`define RST_FLAG_WATCHDOG         16'h0022

// ==========================================================
// Field positions.
`define BIT_LOCK        15
`define BIT_AUTO_REVERT 14
`define BIT_POWER_DOWN  9
`define BIT_SKIP        8
`define BIT_UNLOCK_EVT  14
`define BIT_REF_HALVE_F 6
`define BIT_SKIP_F      5
`define BIT_IDLE_F      4
`define BIT_SLOW_F      3
`define BIT_WDG_F       1
`define BIT_SOFT_F      0
`define BIT_SOFT_RESET  3
`define BIT_REF_HALVE   2
`define BIT_IDLE        1
`define BIT_SLOW        0
`define BIT_DISK_SEL    2

// ==========================================================
// Reset cause codes.
`define CAUSE_HARD     2'h0
`define CAUSE_SOFT     2'h1
`define CAUSE_WATCHDOG 2'h2

// ==========================================================
// Timing: settle time of a mux switch before its flag follows.
`define SWITCH_TIME_NS     20
`define CLOCK_PERIOD_NS    5
`define SWITCH_CYCLES      ((`SWITCH_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SWITCH_CNT_W       3
// Last count of the settle window, SWITCH_CYCLES - 1 at the counter width.
`define SWITCH_LAST_COUNT  3'h3

`endif

// File: rtl/mux_switch_tracker.v
// One clock mux request and its confirmed state.
// Assumes the request is synchronous; the confirmed state follows a stable
// request only after a settle window, mimicking a glitch-free switch.
`timescale 1ns/1ps
`default_nettype none
`include "clock_unit_defines.vh"

module mux_switch_tracker
(
  input  wire clock,
  input  wire reset_n,
  input  wire resetState,
  input  wire request,
  output reg  actual
);

  reg [`SWITCH_CNT_W-1:0] count_reg;

  // ==========================================================
  // Settle counter: restart on any request change, commit at the end.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= {`SWITCH_CNT_W{1'b0}};
      actual    <= 1'b0;
    end
    else if (request == actual)
    begin
      count_reg <= {`SWITCH_CNT_W{1'b0}};
    end
    else if (count_reg == `SWITCH_LAST_COUNT)
    begin
      count_reg <= {`SWITCH_CNT_W{1'b0}};
      actual    <= request;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // The reset value input is unused at asynchronous reset on purpose.
  wire unusedReset = resetState;

endmodule
`default_nettype wire

// File: rtl/pll_clock_reset_control_regs.v
// Register block of the reset and clock unit: PLL setup, dividers, flags.
// Assumes a plain single-cycle register port and a PLL lock input in sync.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_unit_defines.vh"

module pll_clock_reset_control_regs
(
  input  wire        clock,
  input  wire        reset_n,
  input  wire [1:0]  resetCause,
  input  wire [7:0]  address,
  input  wire [15:0] writeData,
  input  wire        writeStrobe,
  input  wire        readStrobe,
  output reg  [15:0] readData,
  input  wire        pllLocked,
  output reg         softResetRequest,
  output wire        pllPowerDown,
  output wire [5:0]  multiplierField,
  output wire [1:0]  outputDividerField,
  output wire [1:0]  peripheralDivider,
  output wire        diskClockSelect,
  output wire        refHalveSelect,
  output wire        useReferenceClock,
  output wire        idleSelect,
  output wire        slowSelect,
  output wire        stopEnable,
  output wire        lockRequest,
  output wire        unlockRequest
);

  reg  [15:0] pllConfiguration_reg;
  reg  [2:0]  dividerConfiguration_reg;
  reg  [2:0]  clockControl_reg;
  reg         lockEvent_reg;
  reg         unlockEvent_reg;
  reg  [1:0]  causeFlags_reg;
  reg  [1:0]  causeSeen_reg;
  reg         causeCaught_reg;
  reg         lockPrev_reg;
  reg         writeUnlock_reg;
  reg  [1:0]  maskEvents_reg;
  reg         maskStop_reg;
  reg         pllSelected_reg;
  reg  [15:0] readData_next;
  wire        lockView;
  wire        protectedWrite;
  wire        lockRise;
  wire        lockFall;
  wire        skipRequest;
  wire        skipActual;
  wire [2:0]  muxRequest;
  wire [2:0]  muxActual;

  // ==========================================================
  // Lock view and edge detection.
  // The lock input is forced low while powered down so a stale lock is never trusted.
  assign lockView = pllLocked & ~pllConfiguration_reg[`BIT_POWER_DOWN];
  assign lockRise = lockView & ~lockPrev_reg;
  assign lockFall = ~lockView & lockPrev_reg;

  // Write decode for the three protected registers.
  assign protectedWrite = writeStrobe & writeUnlock_reg &
                          ((address == `OFS_PLL_CONFIGURATION) |
                           (address == `OFS_DIVIDER_CONFIGURATION) |
                           (address == `OFS_CLOCK_CONTROL));

  // ==========================================================
  // PLL setup register.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pllConfiguration_reg <= `RST_PLL_CONFIGURATION;
    end
    else if (protectedWrite && address == `OFS_PLL_CONFIGURATION)
    begin
      pllConfiguration_reg <= {1'b0, writeData[14], 4'h0, writeData[9:0]};
    end
  end

  // Field outputs; the analog PLL interprets the codes as factors.
  assign pllPowerDown       = pllConfiguration_reg[`BIT_POWER_DOWN];
  assign outputDividerField = pllConfiguration_reg[7:6];
  assign multiplierField    = pllConfiguration_reg[5:0];

  // ==========================================================
  // Divider and control registers.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dividerConfiguration_reg <= 3'h0;
      clockControl_reg         <= 3'h0;
      softResetRequest         <= 1'b0;
    end
    else
    begin
      softResetRequest <= 1'b0;
      if (protectedWrite && address == `OFS_DIVIDER_CONFIGURATION)
      begin
        dividerConfiguration_reg <= writeData[2:0];
      end
      if (protectedWrite && address == `OFS_CLOCK_CONTROL)
      begin
        clockControl_reg <= writeData[2:0];
        softResetRequest <= writeData[`BIT_SOFT_RESET];
      end
    end
  end

  assign diskClockSelect   = dividerConfiguration_reg[`BIT_DISK_SEL];
  assign peripheralDivider = dividerConfiguration_reg[1:0];

  // ==========================================================
  // Unlock bit and interrupt mask.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      writeUnlock_reg <= 1'b0;
      maskEvents_reg  <= 2'h0;
      maskStop_reg    <= 1'b0;
    end
    else
    begin
      if (protectedWrite)
      begin
        writeUnlock_reg <= 1'b0;
      end
      else if (writeStrobe && address == `OFS_WRITE_PROTECT)
      begin
        writeUnlock_reg <= writeData[0];
      end
      if (writeStrobe && address == `OFS_INTERRUPT_MASK)
      begin
        maskEvents_reg <= writeData[15:14];
        maskStop_reg   <= writeData[0];
      end
    end
  end

  assign stopEnable    = maskStop_reg;
  assign lockRequest   = lockEvent_reg & maskEvents_reg[1];
  assign unlockRequest = unlockEvent_reg & maskEvents_reg[0];

  // ==========================================================
  // Lock event flags; a set in the same cycle as a clear wins.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lockPrev_reg    <= 1'b0;
      lockEvent_reg   <= 1'b0;
      unlockEvent_reg <= 1'b0;
    end
    else
    begin
      lockPrev_reg <= lockView;
      if (lockRise)
      begin
        lockEvent_reg <= 1'b1;
      end
      else if (writeStrobe && address == `OFS_CLOCK_FLAG_STATUS && writeData[`BIT_LOCK])
      begin
        lockEvent_reg <= 1'b0;
      end
      if (lockFall)
      begin
        unlockEvent_reg <= 1'b1;
      end
      else if (writeStrobe && address == `OFS_CLOCK_FLAG_STATUS &&
               writeData[`BIT_UNLOCK_EVT])
      begin
        unlockEvent_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Reset cause capture: sampled once by a clocked process after release.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      causeCaught_reg <= 1'b0;
      causeSeen_reg   <= 2'h0;
    end
    else if (!causeCaught_reg)
    begin
      causeCaught_reg <= 1'b1;
      causeSeen_reg   <= resetCause;
    end
  end

  // Cause flags are read only; bus writes never reach them.
  always @*
  begin
    causeFlags_reg = 2'h0;
    case (causeSeen_reg)
      `CAUSE_SOFT:     causeFlags_reg = 2'h1;
      `CAUSE_WATCHDOG: causeFlags_reg = 2'h2;
      default:         causeFlags_reg = 2'h0;
    endcase
  end

  // ==========================================================
  // System clock selection.
  // The PLL path is held while powered down, so clearing the skip bit then
  // changes nothing; after lock loss with auto revert it uses the reference until lock returns.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pllSelected_reg <= 1'b0;
    end
    else if (pllConfiguration_reg[`BIT_SKIP] || pllConfiguration_reg[`BIT_POWER_DOWN])
    begin
      pllSelected_reg <= 1'b0;
    end
    else if (lockFall && pllConfiguration_reg[`BIT_AUTO_REVERT])
    begin
      pllSelected_reg <= 1'b0;
    end
    else if (lockView)
    begin
      pllSelected_reg <= 1'b1;
    end
    else if (!pllConfiguration_reg[`BIT_AUTO_REVERT])
    begin
      pllSelected_reg <= pllSelected_reg;
    end
  end

  assign skipRequest       = ~pllSelected_reg;
  assign useReferenceClock = skipRequest;
  assign refHalveSelect    = clockControl_reg[`BIT_REF_HALVE];
  assign idleSelect        = clockControl_reg[`BIT_IDLE] & ~clockControl_reg[`BIT_SLOW];
  assign slowSelect        = clockControl_reg[`BIT_SLOW];
  assign muxRequest        = {refHalveSelect, idleSelect, slowSelect};

  // ==========================================================
  // Mux trackers: skip mux plus the three mode muxes.
  mux_switch_tracker skipTracker
  (
    .clock      (clock),
    .reset_n    (reset_n),
    .resetState (1'b1),
    .request    (pllSelected_reg),
    .actual     (skipActual)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : muxTrack
      mux_switch_tracker tracker
      (
        .clock      (clock),
        .reset_n    (reset_n),
        .resetState (1'b0),
        .request    (muxRequest[g]),
        .actual     (muxActual[g])
      );
    end
  endgenerate

  // ==========================================================
  // Read mux; unmapped addresses read zero.
  always @*
  begin
    readData_next = 16'h0000;
    case (address)
      `OFS_PLL_CONFIGURATION:
        readData_next = {lockView, pllConfiguration_reg[14:0]};
      `OFS_DIVIDER_CONFIGURATION:
        readData_next = {13'h0000, dividerConfiguration_reg};
      `OFS_CLOCK_FLAG_STATUS:
        readData_next = {lockEvent_reg, unlockEvent_reg, 7'h00,
                         muxActual[2], ~skipActual, muxActual[1], muxActual[0],
                         1'b0, causeFlags_reg};
      `OFS_CLOCK_CONTROL:
        readData_next = {13'h0000, clockControl_reg};
      `OFS_INTERRUPT_MASK:
        readData_next = {maskEvents_reg, 13'h0000, maskStop_reg};
      `OFS_WRITE_PROTECT:
        readData_next = {15'h0000, writeUnlock_reg};
      default:
        readData_next = 16'h0000;
    endcase
  end

  // Read data register: valid only in the cycle after the strobe.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readData <= 16'h0000;
    end
    else if (readStrobe)
    begin
      readData <= readData_next;
    end
    else
    begin
      readData <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// File: test/clock_regs_props.sv
// Port checker for the clock unit register block.
// Assumes the single system clock and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker module.
module clock_regs_checker
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [7:0]  address,
  input wire logic [15:0] writeData,
  input wire logic        writeStrobe,
  input wire logic        readStrobe,
  input wire logic [15:0] readData,
  input wire logic        pllLocked,
  input wire logic        softResetRequest,
  input wire logic        pllPowerDown,
  input wire logic [5:0]  multiplierField,
  input wire logic [1:0]  outputDividerField,
  input wire logic [1:0]  peripheralDivider,
  input wire logic        diskClockSelect,
  input wire logic        refHalveSelect,
  input wire logic        slowSelect,
  input wire logic        useReferenceClock,
  input wire logic        lockRequest
);
  logic unlockSeen;
  logic protWrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Protected offsets share one unlock shadow, so a stale unlock is caught.
  assign protWrite = writeStrobe && (address == 8'h00 || address == 8'h04 || address == 8'h0c);
  // Shadow of the unlock bit; any protected write consumes it.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      unlockSeen <= 1'b0;
    else if (writeStrobe && address == 8'h14)
      unlockSeen <= writeData[0];
    else if (protWrite)
      unlockSeen <= 1'b0;
  end
  locked_write_a: assert property (protWrite && !unlockSeen |=>
    $stable(pllPowerDown) && $stable(multiplierField) && $stable(peripheralDivider)
    && $stable(refHalveSelect)) else $error("locked write changed a register");
  pll_fields_a: assert property (protWrite && unlockSeen && address == 8'h00 |=>
    multiplierField == $past(writeData[5:0]) && outputDividerField == $past(writeData[7:6])
    && pllPowerDown == $past(writeData[9])) else $error("pll setup fields wrong");
  div_fields_a: assert property (protWrite && unlockSeen && address == 8'h04 |=>
    peripheralDivider == $past(writeData[1:0]) && diskClockSelect == $past(writeData[2]))
    else $error("divider fields wrong");
  ctl_fields_a: assert property (protWrite && unlockSeen && address == 8'h0c |=>
    refHalveSelect == $past(writeData[2]) && slowSelect == $past(writeData[0]))
    else $error("control fields wrong");
  soft_reset_a: assert property (protWrite && unlockSeen && address == 8'h0c
    && writeData[3] |=> softResetRequest) else $error("soft reset not raised");
  soft_cause_a: assert property (softResetRequest |-> $past(protWrite && unlockSeen
    && address == 8'h0c && writeData[3])) else $error("soft reset without cause");
  lock_read_a: assert property (readStrobe && address == 8'h00 && pllPowerDown |=>
    !readData[15]) else $error("lock reads one while powered down");
  flag_reserved_a: assert property (readStrobe && address == 8'h08 |=>
    readData[13:7] == 7'h00 && !readData[2]) else $error("reserved flag bits set");
  pll_select_a: assert property ($fell(useReferenceClock) |-> $past(pllLocked)
    && !pllPowerDown) else $error("pll selected while not locked");
  soft_cover: cover property (softResetRequest);
  select_cover: cover property ($fell(useReferenceClock));
  lock_cover: cover property (lockRequest);
endmodule
bind pll_clock_reset_control_regs clock_regs_checker checker_inst (.clock(clock),
  .reset_n(reset_n), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .pllLocked(pllLocked),
  .softResetRequest(softResetRequest), .pllPowerDown(pllPowerDown),
  .multiplierField(multiplierField), .outputDividerField(outputDividerField),
  .peripheralDivider(peripheralDivider), .diskClockSelect(diskClockSelect),
  .refHalveSelect(refHalveSelect), .slowSelect(slowSelect),
  .useReferenceClock(useReferenceClock), .lockRequest(lockRequest));
`default_nettype wire

// File: test/pll_clock_reset_control_regs_bench.sv
// Self-checking bench for the clock unit register block.
// Assumes the design sources in rtl/ and the checker bound from test/.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top.
module pll_clock_reset_control_regs_bench;
  logic        clock;
  logic        reset_n;
  logic [1:0]  resetCause;
  logic [7:0]  address;
  logic [15:0] writeData;
  logic        writeStrobe;
  logic        readStrobe;
  logic        pllLocked;
  logic [15:0] readData;
  logic        softResetRequest;
  logic        pllPowerDown;
  logic [5:0]  multiplierField;
  logic [1:0]  outputDividerField;
  logic [1:0]  peripheralDivider;
  logic        diskClockSelect;
  logic        refHalveSelect;
  logic        useReferenceClock;
  logic        idleSelect;
  logic        slowSelect;
  logic        stopEnable;
  logic        lockRequest;
  logic        unlockRequest;
  int          err_count;
  int          compares;
  pll_clock_reset_control_regs pll_clock_reset_control_regs_inst (.clock(clock),
    .reset_n(reset_n), .resetCause(resetCause), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .pllLocked(pllLocked), .softResetRequest(softResetRequest), .pllPowerDown(pllPowerDown),
    .multiplierField(multiplierField), .outputDividerField(outputDividerField),
    .peripheralDivider(peripheralDivider), .diskClockSelect(diskClockSelect),
    .refHalveSelect(refHalveSelect), .useReferenceClock(useReferenceClock),
    .idleSelect(idleSelect), .slowSelect(slowSelect), .stopEnable(stopEnable),
    .lockRequest(lockRequest), .unlockRequest(unlockRequest));
  // Free-running 200 MHz clock.
  always #2.5 clock = ~clock;
  // ==========================================================
  // Shared tasks.
  task give_verdict;
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  // Bus cycles end just after the taking edge, so results have landed.
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    chk(n, e, readData & m);
  endtask
  task uwr(input logic [7:0] a, input logic [15:0] d);
    wr(8'h14, 16'h0001);
    wr(a, d);
  endtask
  // Mux flags need four stable cycles plus one update cycle.
  task settle;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task do_reset(input logic [1:0] c);
    @(posedge clock);
    reset_n <= 1'b0;
    resetCause <= c;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
  endtask
  // ==========================================================
  // Scenarios.
  task reset_values;
    for (int c = 2; c >= 0; c--)
    begin
      do_reset(c[1:0]);
      rd(8'h08, 16'hffff, 16'h0020 | 16'(c), "flags");
    end
    rd(8'h00, 16'hffff, 16'h03c7, "pll setup");
    rd(8'h0c, 16'hffff, 16'h0000, "control");
    rd(8'h20, 16'hffff, 16'h0000, "unmapped");
  endtask
  task protect_check;
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'hffff, 16'h03c7, "locked write");
    uwr(8'h00, 16'h3d7f);
    rd(8'h00, 16'hffff, 16'h017f, "pll setup");
    chk("fields", 16'h00fd, {multiplierField, outputDividerField});
    wr(8'h00, 16'h0300);
    rd(8'h00, 16'hffff, 16'h017f, "relocked");
  endtask
  task lock_events;
    @(posedge clock);
    pllLocked <= 1'b1;
    settle;
    rd(8'h00, 16'hffff, 16'h817f, "lock bit");
    wr(8'h10, 16'hc001);
    chk("requests", 16'h0005, {lockRequest, unlockRequest, stopEnable});
    uwr(8'h00, 16'h407f);
    settle;
    chk("ref select", 16'h0000, useReferenceClock);
    rd(8'h08, 16'hc020, 16'h8000, "lock flag");
    wr(8'h08, 16'h0000);
    wr(8'h08, 16'h007b);
    rd(8'h08, 16'h807b, 16'h8000, "kept flags");
    wr(8'h08, 16'h8000);
    rd(8'h08, 16'h8000, 16'h0000, "cleared");
    @(posedge clock);
    pllLocked <= 1'b0;
    settle;
    chk("revert", 16'h0003, {useReferenceClock, unlockRequest});
    rd(8'h08, 16'hc020, 16'h4020, "unlock flag");
    wr(8'h08, 16'h4000);
    wr(8'h10, 16'h0000);
  endtask
  task power_skip;
    uwr(8'h00, 16'h037f);
    @(posedge clock);
    pllLocked <= 1'b1;
    uwr(8'h00, 16'h027f);
    settle;
    chk("no switch", 16'h0001, useReferenceClock);
    chk("power down", 16'h0001, pllPowerDown);
    rd(8'h08, 16'h0020, 16'h0020, "skip flag");
  endtask
  task dividers;
    uwr(8'h04, 16'h0006);
    rd(8'h04, 16'hffe7, 16'h0006, "divider reg");
    chk("divider out", 16'h0006, {diskClockSelect, peripheralDivider});
    uwr(8'h04, 16'h0001);
    chk("divider out", 16'h0001, {diskClockSelect, peripheralDivider});
  endtask
  task clock_modes;
    uwr(8'h0c, 16'h0006);
    rd(8'h08, 16'h0058, 16'h0000, "early flags");
    settle;
    chk("modes", 16'h0006, {refHalveSelect, idleSelect, slowSelect});
    rd(8'h08, 16'h0058, 16'h0050, "mode flags");
    uwr(8'h0c, 16'h0001);
    settle;
    chk("modes", 16'h0001, {refHalveSelect, idleSelect, slowSelect});
    rd(8'h08, 16'h0058, 16'h0008, "slow flag");
    uwr(8'h0c, 16'h0008);
    chk("soft reset", 16'h0001, softResetRequest);
  endtask
  // Main sequence; every input has a value at time zero.
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    resetCause = 2'h0;
    address = 8'h00;
    writeData = 16'h0000;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    pllLocked = 1'b0;
    err_count = 0;
    compares = 0;
    reset_values;
    protect_check;
    lock_events;
    power_skip;
    dividers;
    clock_modes;
    give_verdict;
  end
  // A hang is cut short and counted.
  initial
  begin
    #100000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
